// ==== src/mmad_mc_timer.sv ====
// Machine-cycle phase counter: four clocks per machine cycle
`timescale 1ns/1ps
module mmad_mc_timer (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    output logic [1:0]      phase_o,
    output logic            tick_o
);

    logic [1:0] phase_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end

    assign phase_o = phase_q;
    // Tick marks the last clock of each machine cycle
    assign tick_o  = (phase_q == mmad_pkg::MC_LAST_PHASE);

endmodule : mmad_mc_timer

// ==== src/mmad_pkg.sv ====
// Shared constants and carrier types for the memory map and access decoder
package mmad_pkg;

    // Machine-cycle grid
    localparam int unsigned CLKS_PER_MC = 4;
    localparam logic [1:0]  MC_LAST_PHASE = 2'h3;
    localparam logic [1:0]  ALE_PHASES    = 2'h2;

    // Special function register addresses
    localparam logic [7:0] SFR_BASE     = 8'h80;
    localparam logic [7:0] SFR_PORTZ    = 8'h80;
    localparam logic [7:0] SFR_STACK    = 8'h81;
    localparam logic [7:0] SFR_PTR0_LO  = 8'h82;
    localparam logic [7:0] SFR_PTR0_HI  = 8'h83;
    localparam logic [7:0] SFR_PTR1_LO  = 8'h84;
    localparam logic [7:0] SFR_PTR1_HI  = 8'h85;
    localparam logic [7:0] SFR_PTR_SEL  = 8'h86;
    localparam logic [7:0] SFR_STRETCH  = 8'h8E;
    localparam logic [7:0] SFR_MEMPWR   = 8'hC4;
    localparam logic [7:0] SFR_EMPTY    = 8'hFF;

    // Reset values
    localparam logic [7:0] RST_PORTZ    = 8'hFF;
    localparam logic [7:0] RST_STACK    = 8'h07;
    localparam logic [7:0] RST_PTR      = 8'h00;
    localparam logic [2:0] RST_STRETCH  = 3'h1;

    // Field positions and masks
    localparam int unsigned PTR_SEL_BIT   = 0;
    localparam int unsigned SRAM_EN_BIT   = 0;
    localparam int unsigned STRETCH_LSB   = 0;
    localparam logic [7:0]  STRETCH_FILL  = 8'hF8;
    localparam logic [7:0]  MEMPWR_FILL   = 8'hFE;
    localparam logic [2:0]  BIT_ADDR_LOW  = 3'h0;

    // Address space limits
    localparam logic [15:0] SRAM_TOP = 16'h03FF;
    localparam logic [15:0] ROM_TOP  = 16'h7FFF;
    localparam int unsigned SRAM_AW  = 10;
    localparam int unsigned SCR_AW   = 8;

    // Opcodes and cycle counts (counts are machine cycles minus one)
    localparam logic [7:0] OP_PTR_DEC  = 8'hA5;
    localparam logic [2:0] SRAM_CNT    = 3'h1;
    localparam logic [2:0] FETCH_CNT   = 3'h0;

    // External bus strobes, all active low except the latch enable
    typedef struct packed {
        logic ale;
        logic prog_store_n;
        logic rd_n;
        logic wr_n;
    } mmad_strobe_t;

    localparam mmad_strobe_t STROBE_IDLE = '{1'b0, 1'b1, 1'b1, 1'b1};

endpackage : mmad_pkg

// ==== src/mmad_ram.sv ====
// Single-port synchronous byte RAM with registered read data
`timescale 1ns/1ps
module mmad_ram #(
    parameter int unsigned AW = 8
) (
    input  wire logic          clk_i,
    input  wire logic          en_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [7:0]    wdata_i,
    output logic [7:0]         rdata_o
);

    logic [7:0] mem [0:(1<<AW)-1];
    logic [7:0] rdata_q;

    // No reset: contents are undefined until written, as for real SRAM
    always_ff @(posedge clk_i) begin
        if (en_i) begin
            if (we_i) begin
                mem[addr_i] <= wdata_i;
            end
            rdata_q <= mem[addr_i];
        end
    end

    assign rdata_o = rdata_q;

endmodule : mmad_ram

// ==== src/mmad_top.sv ====
// Memory map decoder: register space, pointers, on-chip RAMs, external bus
`timescale 1ns/1ps
module mmad_top (
    input  wire logic                  MCLK_I,
    input  wire logic                  RST_N_I,
    input  wire logic                  EXT_ACCESS_SEL_I,
    input  wire logic [7:0]            MEM_ADDR_I,
    input  wire logic                  MEM_INDIRECT_I,
    input  wire logic                  MEM_RD_I,
    input  wire logic                  MEM_WR_I,
    input  wire logic                  MEM_BIT_I,
    input  wire logic [2:0]            MEM_BITSEL_I,
    input  wire logic [7:0]            MEM_WDATA_I,
    output logic [7:0]                 MEM_RDATA_O,
    output logic                       MEM_RVALID_O,
    output logic                       MEM_REFUSED_O,
    input  wire logic                  OP_VALID_I,
    input  wire logic [7:0]            OPCODE_I,
    output logic                       BUS_READY_O,
    input  wire logic                  EXT_MOVE_REQ_I,
    input  wire logic                  EXT_MOVE_WR_I,
    input  wire logic [15:0]           EXT_MOVE_ADDR_I,
    input  wire logic [7:0]            EXT_MOVE_WDATA_I,
    output logic                       EXT_MOVE_DONE_O,
    output logic [7:0]                 EXT_MOVE_RDATA_O,
    input  wire logic                  FETCH_REQ_I,
    input  wire logic [15:0]           FETCH_ADDR_I,
    output logic                       FETCH_DONE_O,
    output logic                       FETCH_EXT_O,
    output logic [7:0]                 FETCH_DATA_O,
    output logic [15:0]                ACTIVE_DATA_POINTER_O,
    output logic [7:0]                 STACK_TOP_O,
    output logic                       MC_TICK_O,
    output mmad_pkg::mmad_strobe_t     STROBE_O,
    input  wire logic [7:0]            PORT_ZERO_I,
    output logic [7:0]                 PORT_ZERO_O,
    output logic [7:0]                 PORT_ZERO_OE_O,
    output logic [7:0]                 PORT_TWO_O,
    output logic [7:0]                 PORT_TWO_OE_O
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SRAM,
        ST_ADDR,
        ST_STROBE
    } mmad_state_t;

    // Reset release through two flip-flops
    logic rst_s1_q;
    logic rst_n;

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // Machine-cycle grid
    logic [1:0] phase;
    logic       mc_tick;

    mmad_mc_timer u_timer (
        .clk_i   (MCLK_I),
        .rst_n_i (rst_n),
        .phase_o (phase),
        .tick_o  (mc_tick)
    );

    // Pin synchronisers; a change counts once stages two and three agree
    logic [8:0] pin_s1_q;
    logic [8:0] pin_s2_q;
    logic [8:0] pin_s3_q;
    logic [8:0] pin_f_q;
    logic [8:0] pin_f_d;

    assign pin_f_d = (pin_s2_q & pin_s3_q) | (pin_f_q & (pin_s2_q | pin_s3_q));

    always_ff @(posedge MCLK_I or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= 9'h000;
            pin_s2_q <= 9'h000;
            pin_s3_q <= 9'h000;
            pin_f_q  <= 9'h000;
        end else begin
            pin_s1_q <= {EXT_ACCESS_SEL_I, PORT_ZERO_I};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_f_q  <= pin_f_d;
        end
    end

    wire       ext_access_sel = pin_f_q[8];
    wire [7:0] port_zero_pin  = pin_f_q[7:0];

    // Register-space decode
    logic [7:0]  port_zero_latch_q;
    logic [7:0]  stack_top_pointer_q;
    logic [7:0]  ptr_lo_q [0:1];
    logic [7:0]  ptr_hi_q [0:1];
    logic        pointer_select_q;
    logic        internal_sram_enable_q;
    logic [2:0]  stretch_q;
    logic [7:0]  sfr_rdata;

    // Registers only by direct address at 80h and up
    wire sfr_sel = ~MEM_INDIRECT_I & MEM_ADDR_I[7];
    wire scr_sel = ~sfr_sel;
    wire bit_ok  = sfr_sel & (MEM_ADDR_I[2:0] == mmad_pkg::BIT_ADDR_LOW);
    wire bit_bad = MEM_BIT_I & (MEM_RD_I | MEM_WR_I) & ~bit_ok;
    wire acc_ok  = ~MEM_BIT_I | bit_ok;
    wire sfr_wr  = MEM_WR_I & sfr_sel & acc_ok;
    wire scr_wr  = MEM_WR_I & scr_sel & ~MEM_BIT_I;
    wire scr_rd  = MEM_RD_I & scr_sel & ~MEM_BIT_I;

    // Bit writes merge one bit into the current register value
    wire [7:0] bit_mask = 8'h01 << MEM_BITSEL_I;
    wire [7:0] bit_val  = (sfr_rdata & ~bit_mask)
                        | (MEM_WDATA_I[0] ? bit_mask : 8'h00);
    wire [7:0] sfr_wval = MEM_BIT_I ? bit_val : MEM_WDATA_I;

    wire wr_portz   = sfr_wr & (MEM_ADDR_I == mmad_pkg::SFR_PORTZ);
    wire wr_stack   = sfr_wr & (MEM_ADDR_I == mmad_pkg::SFR_STACK);
    wire wr_ptr_sel = sfr_wr & (MEM_ADDR_I == mmad_pkg::SFR_PTR_SEL);
    wire wr_stretch = sfr_wr & (MEM_ADDR_I == mmad_pkg::SFR_STRETCH);
    wire wr_mempwr  = sfr_wr & (MEM_ADDR_I == mmad_pkg::SFR_MEMPWR);
    wire [1:0] wr_lo = {sfr_wr & (MEM_ADDR_I == mmad_pkg::SFR_PTR1_LO),
                        sfr_wr & (MEM_ADDR_I == mmad_pkg::SFR_PTR0_LO)};
    wire [1:0] wr_hi = {sfr_wr & (MEM_ADDR_I == mmad_pkg::SFR_PTR1_HI),
                        sfr_wr & (MEM_ADDR_I == mmad_pkg::SFR_PTR0_HI)};

    wire ptr_dec = OP_VALID_I & (OPCODE_I == mmad_pkg::OP_PTR_DEC);

    // Unimplemented bits fill with ones, except at the pointer select where they read zero; empty addresses read FFh
    always_comb begin
        unique case (MEM_ADDR_I)
            mmad_pkg::SFR_PORTZ:   sfr_rdata = port_zero_latch_q;
            mmad_pkg::SFR_STACK:   sfr_rdata = stack_top_pointer_q;
            mmad_pkg::SFR_PTR0_LO: sfr_rdata = ptr_lo_q[0];
            mmad_pkg::SFR_PTR0_HI: sfr_rdata = ptr_hi_q[0];
            mmad_pkg::SFR_PTR1_LO: sfr_rdata = ptr_lo_q[1];
            mmad_pkg::SFR_PTR1_HI: sfr_rdata = ptr_hi_q[1];
            mmad_pkg::SFR_PTR_SEL: sfr_rdata = {7'h00, pointer_select_q};
            mmad_pkg::SFR_STRETCH: sfr_rdata = mmad_pkg::STRETCH_FILL
                                             | {5'h00, stretch_q};
            mmad_pkg::SFR_MEMPWR:  sfr_rdata = mmad_pkg::MEMPWR_FILL
                                   | {7'h00, internal_sram_enable_q};
            default:               sfr_rdata = mmad_pkg::SFR_EMPTY;
        endcase
    end

    always_ff @(posedge MCLK_I or negedge rst_n) begin
        if (!rst_n) begin
            port_zero_latch_q      <= mmad_pkg::RST_PORTZ;
            stack_top_pointer_q    <= mmad_pkg::RST_STACK;
            pointer_select_q       <= 1'b0;
            internal_sram_enable_q <= 1'b0;
            stretch_q              <= mmad_pkg::RST_STRETCH;
        end else begin
            if (wr_portz) begin
                port_zero_latch_q <= sfr_wval;
            end
            if (wr_stack) begin
                stack_top_pointer_q <= sfr_wval;
            end
            if (wr_ptr_sel) begin
                pointer_select_q <= sfr_wval[mmad_pkg::PTR_SEL_BIT];
            end
            if (wr_stretch) begin
                stretch_q <= sfr_wval[mmad_pkg::STRETCH_LSB +: 3];
            end
            if (wr_mempwr) begin
                internal_sram_enable_q <= sfr_wval[mmad_pkg::SRAM_EN_BIT];
            end
        end
    end

    // Two pointers; a register write in the same cycle beats a decrement
    for (genvar i = 0; i < 2; i++) begin : g_ptr
        wire dec_me = ptr_dec & (pointer_select_q == 1'(i));
        wire [15:0] dec_val = {ptr_hi_q[i], ptr_lo_q[i]} - 16'h0001;
        always_ff @(posedge MCLK_I or negedge rst_n) begin
            if (!rst_n) begin
                ptr_lo_q[i] <= mmad_pkg::RST_PTR;
                ptr_hi_q[i] <= mmad_pkg::RST_PTR;
            end else begin
                if (wr_lo[i]) begin
                    ptr_lo_q[i] <= sfr_wval;
                end else if (dec_me) begin
                    ptr_lo_q[i] <= dec_val[7:0];
                end
                if (wr_hi[i]) begin
                    ptr_hi_q[i] <= sfr_wval;
                end else if (dec_me) begin
                    ptr_hi_q[i] <= dec_val[15:8];
                end
            end
        end
    end

    assign ACTIVE_DATA_POINTER_O = pointer_select_q
                                 ? {ptr_hi_q[1], ptr_lo_q[1]}
                                 : {ptr_hi_q[0], ptr_lo_q[0]};
    assign STACK_TOP_O = stack_top_pointer_q;

    // Scratchpad, its own space apart from the data RAM
    logic [7:0] scr_rdata;

    mmad_ram #(.AW(mmad_pkg::SCR_AW)) u_scratch (
        .clk_i   (MCLK_I),
        .en_i    (scr_rd | scr_wr),
        .we_i    (scr_wr),
        .addr_i  (MEM_ADDR_I),
        .wdata_i (MEM_WDATA_I),
        .rdata_o (scr_rdata)
    );

    logic       rvalid_q;
    logic       rd_scr_q;
    logic       refused_q;
    logic [7:0] sfr_rdata_q;

    always_ff @(posedge MCLK_I or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_q    <= 1'b0;
            rd_scr_q    <= 1'b0;
            refused_q   <= 1'b0;
            sfr_rdata_q <= mmad_pkg::SFR_EMPTY;
        end else begin
            rvalid_q  <= MEM_RD_I & acc_ok;
            rd_scr_q  <= scr_rd;
            refused_q <= bit_bad;
            if (MEM_RD_I & sfr_sel & acc_ok) begin
                sfr_rdata_q <= sfr_rdata;
            end
        end
    end

    assign MEM_RDATA_O   = rd_scr_q ? scr_rdata : sfr_rdata_q;
    assign MEM_RVALID_O  = rvalid_q;
    assign MEM_REFUSED_O = refused_q;

    // Bus sequencer, advancing on the machine-cycle grid
    mmad_state_t state_q;
    logic [2:0]  cnt_q;
    logic        is_fetch_q;
    logic        is_wr_q;
    logic [15:0] addr_q;
    logic [7:0]  wdata_q;
    logic        move_done_q;
    logic        fetch_done_q;
    logic        fetch_ext_q;
    logic [7:0]  move_rdata_q;
    logic [7:0]  fetch_data_q;
    logic [7:0]  sram_rdata;

    wire idle      = (state_q == ST_IDLE);
    wire take      = idle & mc_tick;
    wire take_move = take & EXT_MOVE_REQ_I;
    wire take_ftch = take & ~EXT_MOVE_REQ_I & FETCH_REQ_I;
    wire move_int  = internal_sram_enable_q
                   & (EXT_MOVE_ADDR_I <= mmad_pkg::SRAM_TOP);
    wire ftch_int  = ext_access_sel
                   & (FETCH_ADDR_I <= mmad_pkg::ROM_TOP);
    wire last_mc   = mc_tick & (cnt_q == 3'h0);
    wire sram_go   = take_move & move_int;

    assign BUS_READY_O = take;

    // Internal data RAM is never a fetch target
    mmad_ram #(.AW(mmad_pkg::SRAM_AW)) u_sram (
        .clk_i   (MCLK_I),
        .en_i    (sram_go),
        .we_i    (sram_go & EXT_MOVE_WR_I),
        .addr_i  (EXT_MOVE_ADDR_I[mmad_pkg::SRAM_AW-1:0]),
        .wdata_i (EXT_MOVE_WDATA_I),
        .rdata_o (sram_rdata)
    );

    always_ff @(posedge MCLK_I or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= ST_IDLE;
            cnt_q      <= 3'h0;
            is_fetch_q <= 1'b0;
            is_wr_q    <= 1'b0;
            addr_q     <= 16'h0000;
            wdata_q    <= 8'h00;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (take_move) begin
                        is_fetch_q <= 1'b0;
                        is_wr_q    <= EXT_MOVE_WR_I;
                        addr_q     <= EXT_MOVE_ADDR_I;
                        wdata_q    <= EXT_MOVE_WDATA_I;
                        cnt_q      <= mmad_pkg::SRAM_CNT;
                        state_q    <= move_int ? ST_SRAM : ST_ADDR;
                    end else if (take_ftch & ~ftch_int) begin
                        is_fetch_q <= 1'b1;
                        is_wr_q    <= 1'b0;
                        addr_q     <= FETCH_ADDR_I;
                        state_q    <= ST_ADDR;
                    end
                end
                ST_SRAM: begin
                    if (mc_tick) begin
                        cnt_q <= cnt_q - 3'h1;
                    end
                    if (last_mc) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_ADDR: begin
                    if (mc_tick) begin
                        cnt_q   <= is_fetch_q ? mmad_pkg::FETCH_CNT
                                              : stretch_q;
                        state_q <= ST_STROBE;
                    end
                end
                ST_STROBE: begin
                    if (mc_tick) begin
                        cnt_q <= cnt_q - 3'h1;
                    end
                    if (last_mc) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Pin data lags the bus by the synchroniser, so external answers are
    // taken two clocks after the strobe closes, still before the next take
    wire strobe_end = (state_q == ST_STROBE) & last_mc;
    wire sram_end   = (state_q == ST_SRAM) & last_mc;
    logic [1:0] ext_end_q;
    wire        ext_end = ext_end_q[1];

    always_ff @(posedge MCLK_I or negedge rst_n) begin
        if (!rst_n) begin
            ext_end_q    <= 2'h0;
            move_done_q  <= 1'b0;
            fetch_done_q <= 1'b0;
            fetch_ext_q  <= 1'b0;
            move_rdata_q <= 8'h00;
            fetch_data_q <= 8'h00;
        end else begin
            ext_end_q    <= {ext_end_q[0], strobe_end};
            move_done_q  <= sram_end | (ext_end & ~is_fetch_q);
            fetch_done_q <= (take_ftch & ftch_int) | (ext_end & is_fetch_q);
            if (take_ftch) begin
                fetch_ext_q <= ~ftch_int;
            end
            if (sram_end & ~is_wr_q) begin
                move_rdata_q <= sram_rdata;
            end else if (ext_end & ~is_fetch_q & ~is_wr_q) begin
                move_rdata_q <= port_zero_pin;
            end
            if (ext_end & is_fetch_q) begin
                fetch_data_q <= port_zero_pin;
            end
        end
    end

    assign EXT_MOVE_DONE_O  = move_done_q;
    assign EXT_MOVE_RDATA_O = move_rdata_q;
    assign FETCH_DONE_O     = fetch_done_q;
    assign FETCH_EXT_O      = fetch_ext_q;
    assign FETCH_DATA_O     = fetch_data_q;
    assign MC_TICK_O        = mc_tick;

    // Pin drivers, registered so pins never glitch on decode
    wire in_addr   = (state_q == ST_ADDR);
    wire in_strobe = (state_q == ST_STROBE);
    wire on_bus    = in_addr | in_strobe;

    mmad_pkg::mmad_strobe_t strobe_d;
    mmad_pkg::mmad_strobe_t strobe_q;
    logic [7:0] pz_out_d;
    logic [7:0] pz_oe_d;
    logic [7:0] pz_out_q;
    logic [7:0] pz_oe_q;
    logic [7:0] pt_oe_q;
    logic [7:0] pt_out_q;

    assign strobe_d.ale          = in_addr & (phase < mmad_pkg::ALE_PHASES);
    assign strobe_d.prog_store_n = ~(in_strobe & is_fetch_q);
    assign strobe_d.rd_n         = ~(in_strobe & ~is_fetch_q & ~is_wr_q);
    assign strobe_d.wr_n         = ~(in_strobe & is_wr_q);

    // Address phases and write strobes drive both levels; read and fetch strobes release the pins; otherwise only the zeros are driven
    assign pz_out_d = in_addr ? addr_q[7:0]
                    : (in_strobe ? wdata_q : 8'h00);
    assign pz_oe_d  = in_addr ? 8'hFF
                    : (in_strobe ? {8{is_wr_q}}
                                 : ~port_zero_latch_q);

    always_ff @(posedge MCLK_I or negedge rst_n) begin
        if (!rst_n) begin
            strobe_q <= mmad_pkg::STROBE_IDLE;
            pz_out_q <= 8'h00;
            pz_oe_q  <= 8'h00;
            pt_out_q <= 8'h00;
            pt_oe_q  <= 8'h00;
        end else begin
            strobe_q <= strobe_d;
            pz_out_q <= pz_out_d;
            pz_oe_q  <= pz_oe_d;
            pt_out_q <= addr_q[15:8];
            pt_oe_q  <= {8{on_bus}};
        end
    end

    assign STROBE_O       = strobe_q;
    assign PORT_ZERO_O    = pz_out_q;
    assign PORT_ZERO_OE_O = pz_oe_q;
    assign PORT_TWO_O     = pt_out_q;
    assign PORT_TWO_OE_O  = pt_oe_q;

endmodule : mmad_top

// ==== tb/memory_map_access_decode_tb.sv ====
// Self-checking bench for the memory map decoder
`timescale 1ns/1ps
module memory_map_access_decode_tb;
    logic MCLK_I = 1'h0, RST_N_I = 1'h0, EXT_ACCESS_SEL_I = 1'h1;
    logic MEM_INDIRECT_I = 1'h0, MEM_RD_I = 1'h0, MEM_WR_I = 1'h0;
    logic MEM_BIT_I = 1'h0, OP_VALID_I = 1'h0, FETCH_REQ_I = 1'h0;
    logic EXT_MOVE_REQ_I = 1'h0, EXT_MOVE_WR_I = 1'h0;
    logic [2:0] MEM_BITSEL_I = 3'h3;
    logic [7:0] MEM_ADDR_I = 8'h00, MEM_WDATA_I = 8'h00, OPCODE_I = 8'hA5;
    logic [7:0] EXT_MOVE_WDATA_I = 8'h00, r;
    logic [15:0] EXT_MOVE_ADDR_I = 16'h0000, FETCH_ADDR_I = 16'h0000, p;
    wire [7:0] MEM_RDATA_O, EXT_MOVE_RDATA_O, FETCH_DATA_O, STACK_TOP_O;
    wire [7:0] PORT_ZERO_I, PORT_ZERO_O, PORT_ZERO_OE_O, PORT_TWO_O;
    wire [7:0] PORT_TWO_OE_O, ext_p0;
    wire MEM_RVALID_O, MEM_REFUSED_O, BUS_READY_O, MC_TICK_O, FETCH_EXT_O;
    wire EXT_MOVE_DONE_O, FETCH_DONE_O;
    wire [15:0] ACTIVE_DATA_POINTER_O;
    wire mmad_pkg::mmad_strobe_t STROBE_O;
    int failures = 0, cmp_count = 0, seed = 32'hD5B9, n;
    logic [7:0] ra [10] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85,
                            8'h86, 8'h8E, 8'hC4, 8'hFF};
    logic [7:0] rv [10] = '{8'hFF, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00,
                            8'h00, 8'hF9, 8'hFE, 8'hFF};
    mmad_top u_mmad_top (.*);
    mmad_ext_mem u_mmad_ext_mem (.clk_i(MCLK_I), .strobe_i(STROBE_O),
        .p0_i(PORT_ZERO_I), .p2_i(PORT_TWO_O), .p0_o(ext_p0));
    // Each pin follows the design while it drives, else the memory
    assign PORT_ZERO_I = PORT_ZERO_OE_O & PORT_ZERO_O | ~PORT_ZERO_OE_O & ext_p0;
    always #5 MCLK_I = ~MCLK_I;

    function automatic logic [7:0] emem(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction : emem

    task automatic ck(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'h1) begin
            failures++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : ck

    task automatic acc(input logic w, b, ind, input logic [7:0] a, d, e);
        @(posedge MCLK_I);
        {MEM_ADDR_I, MEM_WDATA_I} <= {a, d};
        {MEM_INDIRECT_I, MEM_BIT_I, MEM_WR_I, MEM_RD_I} <= {ind, b, w, !w};
        @(posedge MCLK_I) {MEM_WR_I, MEM_RD_I, MEM_BIT_I} <= 3'h0;
        #1 ck(w ? MEM_REFUSED_O === e[0]
                : MEM_RVALID_O === 1'h1 && MEM_RDATA_O === e, "access");
    endtask : acc

    task automatic dec(input logic [15:0] e);
        @(posedge MCLK_I) OP_VALID_I <= 1'h1;
        @(posedge MCLK_I) OP_VALID_I <= 1'h0;
        #1 ck(ACTIVE_DATA_POINTER_O === e, "decrement");
    endtask : dec

    task automatic bus(input logic f, w, input logic [15:0] a,
                       input logic [7:0] d, e, input int cyc);
        @(posedge MCLK_I);
        {FETCH_REQ_I, EXT_MOVE_REQ_I, EXT_MOVE_WR_I} <= {f, !f, w};
        {EXT_MOVE_ADDR_I, FETCH_ADDR_I, EXT_MOVE_WDATA_I} <= {a, a, d};
        do @(negedge MCLK_I); while (BUS_READY_O !== 1'h1);
        @(posedge MCLK_I) {FETCH_REQ_I, EXT_MOVE_REQ_I} <= 2'h0;
        n = 1;
        #1;
        while ((f ? FETCH_DONE_O : EXT_MOVE_DONE_O) !== 1'h1 && n < 60) begin
            @(posedge MCLK_I) n++;
            #1;
        end
        ck(n === cyc, "bus cycles");
        if (f) ck(FETCH_EXT_O === (cyc > 1), "fetch side");
        ck(w || cyc == 1 || (f ? FETCH_DATA_O : EXT_MOVE_RDATA_O) === e, "data");
    endtask : bus

    task automatic finish_test();
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test

    // Run takes under 500 cycles; this only cuts a hang short
    initial begin
        #100000;
        failures++;
        finish_test();
    end

    initial begin
        repeat (20) @(posedge MCLK_I);
        RST_N_I <= 1'h1;
        repeat (3) @(posedge MCLK_I);
        #1 ck(STROBE_O === mmad_pkg::STROBE_IDLE && PORT_ZERO_OE_O === 8'h00,
              "reset bus");
        acc(1'h1, 1'h0, 1'h0, 8'hFF, 8'h00, 8'h00);
        foreach (ra[k]) acc(1'h0, 1'h0, 1'h0, ra[k], 8'h00, rv[k]);
        r = 8'($random(seed));
        acc(1'h1, 1'h0, 1'h1, 8'h90, r, 8'h00);
        acc(1'h0, 1'h0, 1'h1, 8'h90, r, r);
        acc(1'h0, 1'h0, 1'h0, 8'h90, r, 8'hFF);
        acc(1'h1, 1'h0, 1'h0, 8'h81, r, 8'h00);
        #1 ck(STACK_TOP_O === r, "stack");
        // Low byte zero forces a borrow into the high byte
        p = 16'($random(seed)) & 16'hFF00;
        acc(1'h1, 1'h0, 1'h0, 8'h85, p[15:8], 8'h00);
        acc(1'h1, 1'h0, 1'h0, 8'h86, 8'h01, 8'h00);
        #1 ck(ACTIVE_DATA_POINTER_O === p, "pointer");
        dec(p - 16'h0001);
        acc(1'h1, 1'h0, 1'h0, 8'h86, 8'h00, 8'h00);
        dec(16'hFFFF);
        bus(1'h0, 1'h1, 16'h0100, r, 8'h00, 15);
        bus(1'h0, 1'h0, 16'h0100, 8'h00, r, 15);
        acc(1'h1, 1'h0, 1'h0, 8'hC4, 8'h01, 8'h00);
        bus(1'h0, 1'h1, 16'h03FF, ~r, 8'h00, 9);
        bus(1'h0, 1'h0, 16'h03FF, 8'h00, ~r, 9);
        bus(1'h0, 1'h0, 16'h0400, 8'h00, emem(16'h0400), 15);
        acc(1'h1, 1'h0, 1'h0, 8'hC4, 8'h00, 8'h00);
        bus(1'h0, 1'h0, 16'h03FF, 8'h00, emem(16'h03FF), 15);
        for (int s = 0; s < 8; s++) begin
            acc(1'h1, 1'h0, 1'h0, 8'h8E, 8'(s), 8'h00);
            p = 16'($random(seed)) | 16'h0400;
            bus(1'h0, 1'h0, p, 8'h00, emem(p), 11 + 4 * s);
        end
        bus(1'h1, 1'h0, 16'h1234, 8'h00, 8'h00, 1);
        bus(1'h1, 1'h0, 16'h8000, 8'h00, emem(16'h8000), 11);
        EXT_ACCESS_SEL_I <= 1'h0;
        repeat (8) @(posedge MCLK_I);
        bus(1'h1, 1'h0, 16'h0010, 8'h00, emem(16'h0010), 11);
        acc(1'h1, 1'h1, 1'h0, 8'h80, 8'h00, 8'h00);
        acc(1'h0, 1'h0, 1'h0, 8'h80, 8'h00, 8'hF7);
        acc(1'h1, 1'h1, 1'h0, 8'h81, 8'h00, 8'h01);
        acc(1'h1, 1'h1, 1'h1, 8'h80, 8'h00, 8'h01);
        finish_test();
    end
endmodule : memory_map_access_decode_tb

// ==== tb/mmad_ext_mem.sv ====
// External memory model on the multiplexed bus
`timescale 1ns/1ps
module mmad_ext_mem (
    input wire logic                   clk_i,
    input wire mmad_pkg::mmad_strobe_t strobe_i,
    input wire logic [7:0]             p0_i,
    input wire logic [7:0]             p2_i,
    output logic [7:0]                 p0_o
);
    logic [7:0]  mem [65536];
    logic [15:0] addr_q = 16'h0000;
    logic [7:0]  junk_q = 8'h00;
    initial for (int i = 0; i < 65536; i++) mem[i] = 8'(i ^ (i >> 8)) ^ 8'h5A;
    always @(posedge clk_i) begin
        junk_q <= junk_q + 8'h35;
        if (strobe_i.ale) addr_q <= {p2_i, p0_i};
        if (!strobe_i.wr_n) mem[addr_q] <= p0_i;
    end
    // Outside a read or program-store strobe the bus shows a moving pattern, never stale data
    assign p0_o = (strobe_i.rd_n && strobe_i.prog_store_n) ? junk_q
                                                           : mem[addr_q];
endmodule : mmad_ext_mem

// ==== tb/mmad_top_props.sv ====
// Port checker for the memory map decoder
`timescale 1ns/1ps
module mmad_top_props (
    input wire logic MCLK_I, RST_N_I, EXT_ACCESS_SEL_I, MEM_INDIRECT_I,
    input wire logic MEM_RD_I, MEM_WR_I, MEM_BIT_I, MEM_RVALID_O,
    input wire logic MEM_REFUSED_O, BUS_READY_O, EXT_MOVE_REQ_I,
    input wire logic EXT_MOVE_DONE_O, FETCH_REQ_I, FETCH_DONE_O,
    input wire logic FETCH_EXT_O, MC_TICK_O,
    input wire logic [7:0] MEM_ADDR_I, PORT_ZERO_OE_O, PORT_TWO_OE_O,
    input wire logic [15:0] FETCH_ADDR_I,
    input wire mmad_pkg::mmad_strobe_t STROBE_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);
    chk_tick_grid: assert property (
        MC_TICK_O |=> !MC_TICK_O [*3] ##1 MC_TICK_O) else $error("tick");
    chk_read_answer: assert property (
        MEM_RD_I && !MEM_BIT_I |=> MEM_RVALID_O) else $error("rvalid");
    chk_bit_refuse: assert property (
        MEM_BIT_I && (MEM_RD_I || MEM_WR_I) && (MEM_INDIRECT_I ||
        !MEM_ADDR_I[7] || MEM_ADDR_I[2:0] != 3'h0)
        |=> MEM_REFUSED_O && !MEM_RVALID_O) else $error("refuse");
    chk_internal_fetch: assert property (
        BUS_READY_O && FETCH_REQ_I && !EXT_MOVE_REQ_I && !FETCH_ADDR_I[15]
        && EXT_ACCESS_SEL_I && $past(EXT_ACCESS_SEL_I, 6)
        |=> FETCH_DONE_O && !FETCH_EXT_O) else $error("int fetch");
    chk_strobe_pulse: assert property (
        $fell(STROBE_O.prog_store_n) |=> !STROBE_O.prog_store_n [*3] ##1
        STROBE_O.prog_store_n ##1 (FETCH_DONE_O && FETCH_EXT_O))
        else $error("program_store_strobe");
    chk_read_release: assert property (
        !STROBE_O.rd_n |-> PORT_ZERO_OE_O == 8'h00 && PORT_TWO_OE_O == 8'hFF)
        else $error("rd bus");
    chk_write_drive: assert property (
        !STROBE_O.wr_n |-> PORT_ZERO_OE_O == 8'hFF && PORT_TWO_OE_O == 8'hFF)
        else $error("wr bus");
    chk_move_length: assert property (
        BUS_READY_O && EXT_MOVE_REQ_I |=> !EXT_MOVE_DONE_O [*8] ##[1:31]
        EXT_MOVE_DONE_O) else $error("move len");
endmodule : mmad_top_props

bind mmad_top mmad_top_props u_mmad_top_props (.*);
